// File: rtl/rpc_regs.sv
// Receive-port paged configuration registers with per-source page select
// ------------------------------------------------------------
// Summary of operation
// - Eight-bit read/write equalizer error limit, reset value one, feeds equalizer.
// - Error count above the limit requests a higher equalizer setting.
// - Offsets 0x44 to 0x49 are read-only and read zero.
// - Capability bit 4 enables the encoder CRC error flag; default off.
// - Capability, embedded type and paged ranges have one bank per port.
// - Read port select bit 4 chooses which bank a paged read returns.
// - Bits 0 and 1 are write enables; paged writes reach every enabled port.
// - Read select defaults 0 locally, arriving port number over back channel.
// - Back channel source's own port write enable defaults one; local both zero.
// - Read-only bit 6 returns 0 locally, arriving port over back channel.
// - Each access source keeps its own page select state.
// - Raw mode line count 0 forwards raw; 1 to 3 relabels first lines.
// - Relabelled lines carry the six-bit embedded code, reset 0x12.
// - Embedded substitution has no effect in CSI-2 input mode.
// ------------------------------------------------------------
module rpc_regs
   import rpc_pkg::*;
#(
   parameter int PAGE_WORDS = 67
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire rpc_req_s req,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire logic [PORTS-1:0][7:0] linkErrCount,
   input wire logic [PORTS-1:0] csiInputMode,
   input wire logic [PORTS-1:0] linkCrcError,
   output logic [7:0] eqErrorLimit,
   output logic [PORTS-1:0] eqRaiseReq,
   output logic [PORTS-1:0] crcErrorFlag,
   output rpc_port_cfg_s [PORTS-1:0] portCfg,
   output logic [PORTS-1:0][1:0] embedLinesEff
);

   // Page word index width and the size of the low paged range
   localparam int IDX_W = $clog2(PAGE_WORDS);
   localparam logic [7:0] PAGE_A_WORDS = OFF_PAGE_A_HI - OFF_PAGE_A_LO + 8'h01;

   // ------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------
   function automatic logic inPagedArray(input logic [7:0] a);
      inPagedArray = (a >= OFF_PAGE_A_LO && a <= OFF_PAGE_A_HI) ||
                     (a >= OFF_PAGE_B_LO && a <= OFF_PAGE_B_HI);
   endfunction

   // Both paged ranges share one memory, the high range after the low one
   function automatic logic [IDX_W-1:0] pageIndex(input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a >= OFF_PAGE_B_LO)
      begin
         d = a - OFF_PAGE_B_LO + PAGE_A_WORDS;
      end
      else
      begin
         d = a - OFF_PAGE_A_LO;
      end
      pageIndex = d[IDX_W-1:0];
   endfunction

   // Source 0 is local; source k>0 is back channel arriving on port k-1
   function automatic logic arrivalPort(input logic [1:0] s);
      arrivalPort = (s == SRC_LOCAL) ? 1'b0 : s[0] ^ 1'b1;
   endfunction

   // Unused source code 3 falls back to the local page state
   function automatic logic [1:0] srcSlot(input logic [1:0] s);
      srcSlot = (s < 2'(SRCS)) ? s : SRC_LOCAL;
   endfunction

   // Read-only reserved span
   function automatic logic inReserved(input logic [7:0] a);
      inReserved = a >= OFF_RSVD_LO && a <= OFF_RSVD_HI;
   endfunction

   logic wr;
   logic rd;
   assign wr = req.valid && req.write;
   assign rd = req.valid && !req.write;

   // ------------------------------------------------------------
   // Equalizer error limit
   // ------------------------------------------------------------
   logic [7:0] errLimit_q;
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         errLimit_q <= RST_ERR_LIMIT;
      end
      else if (wr && req.addr == OFF_ERR_LIMIT)
      begin
         errLimit_q <= req.wdata;
      end
   end

   // ------------------------------------------------------------
   // Page select state, one copy per source
   // ------------------------------------------------------------
   logic [SRCS-1:0] readSel_q;
   logic [SRCS-1:0][PORTS-1:0] writeEn_q;
   genvar gs;
   generate
      for (gs = 0; gs < SRCS; gs++)
      begin : g_src
         localparam logic [1:0] SID = 2'(gs);
         localparam logic RST_RD = arrivalPort(SID);
         localparam logic [PORTS-1:0] RST_WEN = (SID == SRC_LOCAL) ? 2'h0 : (2'h1 << RST_RD);
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               readSel_q[gs] <= RST_RD;
            end
            else if (wr && req.src == SID && req.addr == OFF_PAGE_SEL)
            begin
               readSel_q[gs] <= req.wdata[BIT_READ_PORT];
            end
         end
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               writeEn_q[gs] <= RST_WEN;
            end
            else if (wr && req.src == SID && req.addr == OFF_PAGE_SEL)
            begin
               writeEn_q[gs] <= {req.wdata[BIT_WEN1], req.wdata[BIT_WEN0]};
            end
         end
      end
   endgenerate

   logic curRead;
   logic [PORTS-1:0] curWen;
   assign curRead = readSel_q[srcSlot(req.src)];
   assign curWen = writeEn_q[srcSlot(req.src)];

   // ------------------------------------------------------------
   // Per-port banks
   // ------------------------------------------------------------
   logic [PORTS-1:0][7:0] linkCap_q;
   logic [PORTS-1:0][7:0] embed_q;
   logic [7:0] pageMem [PORTS][PAGE_WORDS];
   genvar gp;
   generate
      for (gp = 0; gp < PORTS; gp++)
      begin : g_port
         logic bankWr;
         assign bankWr = wr && curWen[gp];
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               linkCap_q[gp] <= RST_LINK_CAP;
            end
            else if (bankWr && req.addr == OFF_LINK_CAP)
            begin
               linkCap_q[gp] <= req.wdata;
            end
         end
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               embed_q[gp] <= RST_EMBED;
            end
            else if (bankWr && req.addr == OFF_EMBED)
            begin
               embed_q[gp] <= req.wdata;
            end
         end
         always_ff @(posedge mclk)
         begin
            if (bankWr && inPagedArray(req.addr))
            begin
               pageMem[gp][pageIndex(req.addr)] <= req.wdata;
            end
         end

         // Datapath-facing outputs, one flop group per concern
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               eqRaiseReq[gp] <= 1'b0;
            end
            else
            begin
               eqRaiseReq[gp] <= linkErrCount[gp] > errLimit_q;
            end
         end
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               crcErrorFlag[gp] <= 1'b0;
            end
            else
            begin
               crcErrorFlag[gp] <= linkCrcError[gp] && linkCap_q[gp][BIT_CRC_FLAG];
            end
         end
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               portCfg[gp] <= '0;
            end
            else
            begin
               portCfg[gp] <= {linkCap_q[gp][BIT_CRC_FLAG], embed_q[gp]};
            end
         end
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               embedLinesEff[gp] <= 2'h0;
            end
            else
            begin
               embedLinesEff[gp] <= csiInputMode[gp] ? 2'h0 :
                                    embed_q[gp][EMB_CNT_LSB +: 2];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Read data path
   // ------------------------------------------------------------
   logic [7:0] rmux;
   always_comb
   begin
      rmux = RSVD_VALUE;
      if (req.addr == OFF_ERR_LIMIT)
      begin
         rmux = errLimit_q;
      end
      else if (inReserved(req.addr))
      begin
         rmux = RSVD_VALUE;
      end
      else if (req.addr == OFF_LINK_CAP)
      begin
         rmux = linkCap_q[curRead];
      end
      else if (req.addr == OFF_EMBED)
      begin
         rmux = embed_q[curRead];
      end
      else if (req.addr == OFF_PAGE_SEL)
      begin
         rmux[BIT_PHYS] = arrivalPort(req.src);
         rmux[BIT_READ_PORT] = curRead;
         rmux[BIT_WEN1] = curWen[1];
         rmux[BIT_WEN0] = curWen[0];
      end
      else if (inPagedArray(req.addr))
      begin
         rmux = pageMem[curRead][pageIndex(req.addr)];
      end
   end

   // ------------------------------------------------------------
   // Bus answer and limit copy
   // ------------------------------------------------------------
   // Read data holds until the next read
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata <= 8'h00;
      end
      else if (rd)
      begin
         rdata <= rmux;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rvalid <= 1'b0;
      end
      else
      begin
         rvalid <= rd;
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         eqErrorLimit <= RST_ERR_LIMIT;
      end
      else
      begin
         eqErrorLimit <= errLimit_q;
      end
   end

endmodule

// File: rtl/rpc_pkg.sv
// Package for the receive-port paged configuration register block
package rpc_pkg;
   localparam int PORTS = 2;
   localparam int SRCS = 3;
   localparam logic [7:0] OFF_ERR_LIMIT = 8'h43;
   localparam logic [7:0] OFF_RSVD_LO = 8'h44;
   localparam logic [7:0] OFF_RSVD_HI = 8'h49;
   localparam logic [7:0] OFF_LINK_CAP = 8'h4A;
   localparam logic [7:0] OFF_EMBED = 8'h4B;
   localparam logic [7:0] OFF_PAGE_SEL = 8'h4C;
   localparam logic [7:0] OFF_PAGE_A_LO = 8'h4D;
   localparam logic [7:0] OFF_PAGE_A_HI = 8'h7F;
   localparam logic [7:0] OFF_PAGE_B_LO = 8'hD0;
   localparam logic [7:0] OFF_PAGE_B_HI = 8'hDF;
   localparam logic [7:0] RST_ERR_LIMIT = 8'h01;
   localparam logic [7:0] RST_LINK_CAP = 8'h00;
   localparam logic [7:0] RST_EMBED = 8'h12;
   localparam logic [7:0] RSVD_VALUE = 8'h00;
   localparam int BIT_CRC_FLAG = 4;
   localparam int BIT_READ_PORT = 4;
   localparam int BIT_PHYS = 6;
   localparam int BIT_WEN1 = 1;
   localparam int BIT_WEN0 = 0;
   localparam int EMB_CNT_LSB = 6;
   localparam int EMB_CODE_W = 6;
   localparam logic [1:0] SRC_LOCAL = 2'h0;

   // One register access from one master
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] src;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rpc_req_s;

   // Per-port settings handed to the link datapath
   typedef struct packed {
      logic crcFlagEn;
      logic [1:0] embedLines;
      logic [EMB_CODE_W-1:0] embedCode;
   } rpc_port_cfg_s;
endpackage

// File: test/rpc_regs_checker.sv
// Checker for the paged configuration register block
module rpc_regs_checker
   import rpc_pkg::*;
#(
   parameter int PAGE_WORDS = 67
)
(
   input wire logic mclk,
   input wire logic rstn,
   input wire rpc_req_s req,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic [PORTS-1:0][7:0] linkErrCount,
   input wire logic [PORTS-1:0] csiInputMode,
   input wire logic [PORTS-1:0] linkCrcError,
   input wire logic [7:0] eqErrorLimit,
   input wire logic [PORTS-1:0] eqRaiseReq,
   input wire logic [PORTS-1:0] crcErrorFlag,
   input wire rpc_port_cfg_s [PORTS-1:0] portCfg,
   input wire logic [PORTS-1:0][1:0] embedLinesEff
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   logic rdStb;
   assign rdStb = req.valid && !req.write;
   read_answer_a: assert property (rdStb |=> rvalid)
      else $error("read not answered");
   no_spurious_a: assert property (!rdStb |=> !rvalid)
      else $error("answer without read");
   rdata_hold_a: assert property (!rdStb |=> $stable(rdata))
      else $error("read data moved without read");
   limit_change_a: assert property ($changed(eqErrorLimit)
      |-> $past(req.valid && req.write && req.addr == OFF_ERR_LIMIT, 2))
      else $error("error limit changed without write");
   raise_req_a: assert property ($past(rstn) |-> eqRaiseReq ==
      {$past(linkErrCount[1]) > eqErrorLimit, $past(linkErrCount[0]) > eqErrorLimit})
      else $error("raise request wrong");
   crc_gate_a: assert property ($past(rstn) |-> (crcErrorFlag & ~$past(linkCrcError)) == '0)
      else $error("crc flag without error");
   crc_follow_a: assert property ($past(rstn) |-> crcErrorFlag ==
      ($past(linkCrcError) & {portCfg[1].crcFlagEn, portCfg[0].crcFlagEn}))
      else $error("crc flag not gated by enable");
   raw_lines0_a: assert property (!csiInputMode[0] |=>
      embedLinesEff[0] == portCfg[0].embedLines)
      else $error("port 0 raw line count lost");
   raw_lines1_a: assert property (!csiInputMode[1] |=>
      embedLinesEff[1] == portCfg[1].embedLines)
      else $error("port 1 raw line count lost");
   csi_mask0_a: assert property (csiInputMode[0] |=> embedLinesEff[0] == 2'h0)
      else $error("port 0 embed active in csi mode");
   csi_mask1_a: assert property (csiInputMode[1] |=> embedLinesEff[1] == 2'h0)
      else $error("port 1 embed active in csi mode");
   cover property (rdStb ##1 rvalid);
   cover property (eqRaiseReq[0]);
   cover property (crcErrorFlag[0]);
   cover property (embedLinesEff[1] != 2'h0);
endmodule

bind rpc_regs rpc_regs_checker #(.PAGE_WORDS(PAGE_WORDS)) chk (.mclk(mclk), .rstn(rstn),
   .req(req), .rdata(rdata), .rvalid(rvalid), .linkErrCount(linkErrCount),
   .csiInputMode(csiInputMode), .linkCrcError(linkCrcError), .eqErrorLimit(eqErrorLimit),
   .eqRaiseReq(eqRaiseReq), .crcErrorFlag(crcErrorFlag), .portCfg(portCfg),
   .embedLinesEff(embedLinesEff));

// File: test/rpc_host_model.sv
// Register master model: local host or remote master over the back channel
module rpc_host_model
   import rpc_pkg::*;
(
   input wire logic mclk,
   output rpc_req_s req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // Idle drives inverted fields so stale values never look valid
   task automatic access(input logic wr, input logic [1:0] s, input logic [7:0] a, d);
      req <= '{1'b1, wr, s, a, d};
      @(posedge mclk);
      req <= '{1'b0, ~wr, ~s, ~a, ~d};
      @(posedge mclk);
   endtask
endmodule

// File: test/test_rpc_regs.sv
// Self-checking testbench for the paged configuration register block
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errTotal++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_rpc_regs;
   import rpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rstn, rvalid;
   rpc_req_s req;
   logic [7:0] rdata, eqErrorLimit, lim, x, y, expV;
   logic [PORTS-1:0][7:0] linkErrCount;
   logic [PORTS-1:0] csiInputMode, linkCrcError, eqRaiseReq, crcErrorFlag;
   rpc_port_cfg_s [PORTS-1:0] portCfg;
   logic [PORTS-1:0][1:0] embedLinesEff;
   int errTotal = 0;
   int compares = 0;
   logic [7:0] expQ[$];
   rpc_regs dut (.mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
      .linkErrCount(linkErrCount), .csiInputMode(csiInputMode),
      .linkCrcError(linkCrcError), .eqErrorLimit(eqErrorLimit), .eqRaiseReq(eqRaiseReq),
      .crcErrorFlag(crcErrorFlag), .portCfg(portCfg), .embedLinesEff(embedLinesEff));
   rpc_host_model host (.mclk(mclk), .req(req));
   task automatic wr(input logic [1:0] s, input logic [7:0] a, d);
      host.access(1'b1, s, a, d);
   endtask
   task automatic rd(input logic [1:0] s, input logic [7:0] a, e);
      expQ.push_back(e);
      host.access(1'b0, s, a, 8'h00);
   endtask
   task automatic wrap_up;
      `CHK("pendingReads", 0, expQ.size())
      $display("compares %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Datapath inputs toggle freely; the checker judges them
   always @(posedge mclk)
   begin
      linkErrCount <= 16'($urandom);
      csiInputMode <= 2'($urandom);
      linkCrcError <= 2'($urandom);
   end
   always @(posedge mclk)
   begin
      if (rvalid === 1'b1)
      begin
         expV = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
         `CHK("rdata", expV, rdata)
      end
   end
   initial
   begin
      #100us;
      errTotal++;
      wrap_up;
   end
   initial
   begin
      void'($urandom(32'hF0882328));
      rstn = 1'b0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rd(0, OFF_ERR_LIMIT, RST_ERR_LIMIT);
      rd(0, OFF_LINK_CAP, RST_LINK_CAP);
      rd(0, OFF_EMBED, RST_EMBED);
      rd(0, OFF_PAGE_SEL, 8'h00);
      rd(1, OFF_PAGE_SEL, 8'h01);
      rd(2, OFF_PAGE_SEL, 8'h52);
      for (int a = 8'h44; a <= 8'h49; a++)
      begin
         wr(0, 8'(a), 8'hFF);
         rd(0, 8'(a), RSVD_VALUE);
      end
      rd(0, 8'h20, 8'h00);
      lim = 8'($urandom_range(255, 1));
      wr(0, OFF_ERR_LIMIT, lim);
      rd(0, OFF_ERR_LIMIT, lim);
      x = 8'($urandom);
      y = ~x;
      wr(0, OFF_EMBED, x);
      rd(0, OFF_EMBED, RST_EMBED);
      wr(0, OFF_PAGE_SEL, 8'h03);
      wr(0, OFF_EMBED, x);
      wr(0, OFF_LINK_CAP, 8'h10);
      rd(0, OFF_EMBED, x);
      wr(0, OFF_PAGE_SEL, 8'h11);
      rd(0, OFF_PAGE_SEL, 8'h11);
      rd(0, OFF_EMBED, x);
      wr(0, OFF_EMBED, y);
      rd(0, OFF_EMBED, x);
      rd(2, OFF_LINK_CAP, 8'h10);
      `CHK("portCfg0", {1'b1, y}, portCfg[0])
      `CHK("portCfg1", {1'b1, x}, portCfg[1])
      wr(0, OFF_PAGE_SEL, 8'h00);
      rd(0, OFF_EMBED, y);
      rd(1, OFF_PAGE_SEL, 8'h01);
      wr(1, OFF_EMBED, 8'hC5);
      rd(0, OFF_EMBED, 8'hC5);
      wr(0, OFF_PAGE_SEL, 8'h03);
      wr(0, 8'h4F, x);
      wr(0, OFF_PAGE_B_HI, y);
      rd(0, 8'h4F, x);
      rd(2, OFF_PAGE_B_HI, y);
      repeat (40) @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rd(0, OFF_ERR_LIMIT, RST_ERR_LIMIT);
      repeat (4) @(posedge mclk);
      wrap_up;
   end
endmodule
